// [bench/lsb_link_chk.sv]
// Purpose: wire checks on the transmit backplane
// Assumes: one clk_sys domain, rst high active
// Notes: watches interface signals only
`timescale 1ns/1ps
module lsb_link_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic devClockOut,
  input wire logic devClockOe,
  input wire logic devPulseOut,
  input wire logic devPulseOe,
  input wire logic sysClockOe,
  input wire logic sysPulseOe,
  input wire logic txSystemClock,
  input wire logic txSystemFramePulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ownership of the shared pins
  chk_one_owner: assert property (!(devClockOe && sysClockOe))
    else $error("both ends drive the clock");
  chk_dev_pair: assert property (devClockOe == devPulseOe)
    else $error("device clock and pulse enables differ");
  chk_sys_pair: assert property (sysClockOe == sysPulseOe)
    else $error("system clock and pulse enables differ");
  // resolved levels follow the device end when it drives, clock low when undriven
  chk_clk_follow: assert property
    (devClockOe |-> txSystemClock == devClockOut)
    else $error("clock pin not from device");
  chk_pulse_follow: assert property
    (devPulseOe |-> txSystemFramePulse == devPulseOut)
    else $error("pulse pin not from device");
  chk_idle_low: assert property
    (!devClockOe && !sysClockOe |-> !txSystemClock)
    else $error("undriven clock not low");
  // device clock high phase is bounded on both sides
  chk_high_min: assert property ($rose(txSystemClock) && devClockOe
    |=> (txSystemClock || !devClockOe)[*3])
    else $error("clock high phase too short");
  chk_high_max: assert property (devClockOe && $rose(devClockOut)
    |-> ##[1:9] (!devClockOut || !devClockOe))
    else $error("clock high phase too long");
endmodule

// [bench/tb.sv]
// Purpose: bench for the register group and backplane pair
// Assumes: 100 MHz clk_sys, short frames of 8 bits
// Notes: reads and captured bits checked from queues
`timescale 1ns/1ps
module tb;
  import lsb_pkg::*;
  logic        clk_sys = 0;
  logic        rst = 1;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, blockIrq0 = 0, blockIrq1 = 0;
  logic [3:0]  s_axi_wstrb = 4'hF, excessZeroError = 0;
  logic [3:0]  signalLossStatus = 0, lineInterfaceIrqSummary = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic        s_axi_bready = 1, s_axi_rready = 1, devIsMaster = 0;
  logic        txBitIn = 0, txSigIn = 0, t;
  logic [5:0]  opt = 0;
  logic [7:0]  v;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [3:0]  referenceOutputA, referenceOutputB;
  wire         capData, capSignaling, capValid, capFrameStart;
  wire         bitTaken, frameStart;
  wire         sampleClockPolarity = opt[DE_BIT];
  wire         pulseClockPolarity = opt[FE_BIT];
  wire         clockDoubleRate = opt[CMS_BIT];
  wire         framePulsePolarity = opt[FRAME_PULSE_POLARITY_BIT];
  wire         framePulseKind = opt[FRAME_PULSE_KIND_BIT];
  integer      seed = 32'h501C, mismatches = 0, cmp_count = 0, skip = 0;
  integer      age = 0;
  logic [33:0] rdQ[$];
  logic [1:0]  bitQ[$];
  lsb_link_if lnk();
  lsb_device #(.FRM_BITS(8), .SF_LEN(2)) lsb_device_inst (.*, .lnk(lnk));
  lsb_system #(.FRM_BITS(8), .SF_LEN(2)) lsb_system_inst (.*, .lnk(lnk));
  lsb_link_chk lsb_link_chk_inst (.clk_sys(clk_sys), .rst(rst),
    .devClockOut(lnk.devClockOut), .devClockOe(lnk.devClockOe),
    .devPulseOut(lnk.devPulseOut), .devPulseOe(lnk.devPulseOe),
    .sysClockOe(lnk.sysClockOe), .sysPulseOe(lnk.sysPulseOe),
    .txSystemClock(lnk.txSystemClock),
    .txSystemFramePulse(lnk.txSystemFramePulse));
  // clock
  always #5 clk_sys = ~clk_sys;
  task automatic cmp(input logic [33:0] e, input logic [33:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input [1:0] l, input [7:0] o, input [7:0] d);
    logic a, w;
    a = 0;
    w = 0;
    rdQ.push_back({RESP_OKAY, 32'h0});
    s_axi_awaddr <= {l, o, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(a && w))
    begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready)
      begin
        a = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
  endtask
  task automatic rd(input [1:0] l, input [7:0] o, input [33:0] e);
    rdQ.push_back(e);
    s_axi_araddr <= {l, o, 2'b00};
    s_axi_arvalid <= 1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
  endtask
  // result monitor: read answers and captured bits
  always @(posedge clk_sys)
  begin
    if (s_axi_rvalid) cmp(rdQ.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid) cmp(rdQ.pop_front(), {s_axi_bresp, 32'h0});
    // captures within two cycles of a restart belong to older bits
    if (capValid && skip == 0 && age > 2 && bitQ.size() > 0)
      cmp(bitQ.pop_front(), {capSignaling, capData});
    if (bitTaken)
    begin
      if (skip == 2)
      begin
        bitQ.delete();
        skip = 0;
        age = 0;
      end
      bitQ.push_back({txSigIn, txBitIn});
      {txSigIn, txBitIn} <= $random(seed);
    end
    age++;
  end
  task complete_run;
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #1_000_000;
    mismatches++;
    complete_run;
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    blockIrq0 <= $random(seed);
    blockIrq1 <= $random(seed);
    {signalLossStatus, lineInterfaceIrqSummary} <= $random(seed);
    for (int l = 0; l < 4; l++)
    begin
      rd(l, OFF_TX_OPT, 0);
      rd(l, OFF_TX_MODE, 1);
      rd(l, OFF_CNT_LO, 0);
      rd(l, OFF_MOD_IND0, blockIrq0[8*l+:8]);
      rd(l, OFF_MOD_IND1, blockIrq1[8*l+:8]);
      rd(l, OFF_MOD_IND2, lineInterfaceIrqSummary[l]);
      rd(l, 8'h36, signalLossStatus[l]);
    end
    blockIrq0 <= 0;
    rd(3, OFF_MOD_IND0, 0);
    rd(0, 8'h00, {RESP_SLVERR, 32'h0});
    repeat (300)
    begin
      excessZeroError <= 4'h2;
      @(posedge clk_sys);
      excessZeroError <= 0;
      @(posedge clk_sys);
    end
    rd(1, OFF_CNT_HI, 8'h01);
    excessZeroError <= 4'h2;
    @(posedge clk_sys);
    excessZeroError <= 0;
    rd(1, OFF_CNT_LO, 8'h2C);
    // run the count past its top to raise the overflow flag
    excessZeroError <= 4'h2;
    repeat (CNT_MAX - 300) @(posedge clk_sys);
    excessZeroError <= 0;
    rd(1, OFF_CNT_HI, 0);
    rd(1, OFF_IRQ_STATUS1, 1);
    wr(1, OFF_IRQ_STATUS1, 1);
    rd(1, OFF_IRQ_STATUS1, 0);
    wr(2, OFF_REF_CTRL, 1);
    rd(2, OFF_REF_CTRL, 1);
    signalLossStatus <= 4'h4;
    repeat (4) @(posedge clk_sys);
    cmp(3, {referenceOutputB[2], referenceOutputA[2]});
    wr(2, OFF_REF_CTRL, 0);
    repeat (3) @(posedge clk_sys);
    t = referenceOutputA[2];
    @(posedge clk_sys);
    cmp(!t, referenceOutputA[2]);
    for (int k = 0; k < 6; k++)
    begin
      v = $random(seed) & 8'h3F;
      v[1:0] = k[1:0];
      skip = 1;
      devIsMaster <= k >= 3;
      wr(0, OFF_TX_MODE, k < 3);
      for (int l = 0; l < 4; l++) wr(l, OFF_TX_OPT, v);
      rd(0, OFF_TX_OPT, v);
      opt <= v[5:0];
      repeat (200) @(posedge clk_sys);
      skip = 2;
      repeat (1800) @(posedge clk_sys);
    end
    complete_run;
  end
endmodule

// [core/lsb_device.sv]
// Purpose: per-link status, indication and transmit backplane registers
//   with the transmit backplane capture of link 0.
// Assumes: event and status inputs come from logic on clk_sys.
// Notes: one write and one read under way at a time on the bus.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module lsb_device #(
  parameter int LNK_N = lsb_pkg::LINKS,
  parameter int FRM_BITS = lsb_pkg::FRAME_BITS,
  parameter int SF_LEN = lsb_pkg::SF_FRAMES,
  parameter int HALF_CYC = lsb_pkg::LINK_HALF_CYC
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic [lsb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [lsb_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic [LNK_N-1:0]          excessZeroError,
  input  wire logic [LNK_N-1:0]          signalLossStatus,
  input  wire logic [LNK_N-1:0]          lineInterfaceIrqSummary,
  input  wire logic [LNK_N*8-1:0]        blockIrq0,
  input  wire logic [LNK_N*8-1:0]        blockIrq1,
  output logic [LNK_N-1:0]               referenceOutputA,
  output logic [LNK_N-1:0]               referenceOutputB,
  output logic                           capData,
  output logic                           capSignaling,
  output logic                           capValid,
  output logic                           capFrameStart,
  lsb_link_if.dev                        lnk
);
  import lsb_pkg::*;

  logic [15:0]      count_reg [LNK_N];
  logic [7:0]       snapLow_reg [LNK_N];
  logic [OPT_W-1:0] txOpt_reg [LNK_N];
  logic [LNK_N-1:0] overflow_reg;
  logic [LNK_N-1:0] refHold_reg;
  logic [LNK_N-1:0] txMode_reg;
  logic             awHave_reg;
  logic             wHave_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0]      wData_reg;
  logic             wLow_reg;
  logic             mclk_reg;
  logic [1:0]       wrLink;
  logic [7:0]       wrOff;
  logic [1:0]       rdLink;
  logic [7:0]       rdOff;
  logic [31:0]      rdData;
  logic             rdOk;
  logic             doWrite;
  logic             wrHit;
  logic             awTake;
  logic             wTake;
  logic             arTake;

  assign awTake = s_axi_awvalid && s_axi_awready;
  assign wTake = s_axi_wvalid && s_axi_wready;
  assign arTake = s_axi_arvalid && s_axi_arready;
  assign doWrite = awHave_reg && wHave_reg && !s_axi_bvalid;
  assign wrHit = doWrite && wLow_reg;
  assign wrLink = awAddr_reg[LINK_LSB+1:LINK_LSB];
  assign wrOff = awAddr_reg[LINK_LSB-1:OFF_LSB];
  assign rdLink = s_axi_araddr[LINK_LSB+1:LINK_LSB];
  assign rdOff = s_axi_araddr[LINK_LSB-1:OFF_LSB];

  // write address channel, taken once per write
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      awHave_reg <= 1'b0;
      awAddr_reg <= '0;
    end
    else if (awTake)
    begin
      s_axi_awready <= 1'b0;
      awHave_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end
    else if (doWrite)
      awHave_reg <= 1'b0;
    else if (!awHave_reg && !s_axi_bvalid)
      s_axi_awready <= 1'b1;

  // write data channel, either order with the address
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      s_axi_wready <= 1'b0;
      wHave_reg <= 1'b0;
      wData_reg <= '0;
      wLow_reg <= 1'b0;
    end
    else if (wTake)
    begin
      s_axi_wready <= 1'b0;
      wHave_reg <= 1'b1;
      wData_reg <= s_axi_wdata;
      wLow_reg <= s_axi_wstrb[0];
    end
    else if (doWrite)
      wHave_reg <= 1'b0;
    else if (!wHave_reg && !s_axi_bvalid)
      s_axi_wready <= 1'b1;

  // write response once both halves are in
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wrOff >= OFF_LOS_STATUS && wrOff <= OFF_TX_MODE)
                     ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;

  // software settings per link
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      for (int k = 0; k < LNK_N; k++)
      begin
        txOpt_reg[k] <= TX_OPT_RST;
        refHold_reg[k] <= HOLD_RST;
        txMode_reg[k] <= TX_MODE_RST;
      end
    end
    else if (wrHit)
    begin
      for (int k = 0; k < LNK_N; k++)
        if (wrLink == 2'(k))
        begin
          if (wrOff == OFF_TX_OPT)
            txOpt_reg[k] <= wData_reg[OPT_W-1:0];
          else if (wrOff == OFF_REF_CTRL)
            refHold_reg[k] <= wData_reg[HOLD_BIT];
          else if (wrOff == OFF_TX_MODE)
            txMode_reg[k] <= wData_reg[TX_TIMING_SUBMODE_BIT];
        end
    end

  // read data decode, indications sampled live
  always_comb
  begin
    rdData = '0;
    rdOk = 1'b1;
    if (rdOff == OFF_LOS_STATUS)
      rdData[LOS_BIT] = signalLossStatus[rdLink];
    else if (rdOff == OFF_IRQ_STATUS1)
      rdData[OVF_BIT] = overflow_reg[rdLink];
    else if (rdOff == OFF_CNT_HI)
      rdData[7:0] = count_reg[rdLink][15:8];
    else if (rdOff == OFF_CNT_LO)
      rdData[7:0] = snapLow_reg[rdLink];
    else if (rdOff == OFF_REF_CTRL)
      rdData[HOLD_BIT] = refHold_reg[rdLink];
    else if (rdOff == OFF_MOD_IND2)
      rdData[LIU_BIT] = lineInterfaceIrqSummary[rdLink];
    else if (rdOff == OFF_MOD_IND0)
      rdData[7:0] = blockIrq0[rdLink*8 +: 8];
    else if (rdOff == OFF_MOD_IND1)
      rdData[7:0] = blockIrq1[rdLink*8 +: 8];
    else if (rdOff == OFF_TX_OPT)
      rdData[OPT_W-1:0] = txOpt_reg[rdLink];
    else if (rdOff == OFF_TX_MODE)
      rdData[TX_TIMING_SUBMODE_BIT] = txMode_reg[rdLink];
    else
      rdOk = 1'b0;
  end

  // read channel, answer one cycle after the address is taken
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (arTake)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdData;
      s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;

  // master clock source for the reference outputs
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      mclk_reg <= 1'b0;
    else
      mclk_reg <= !mclk_reg;

  for (genvar g = 0; g < LNK_N; g++)
  begin : gLink
    // error counter wraps past its top
    always_ff @(posedge clk_sys or posedge rst)
      if (rst)
        count_reg[g] <= '0;
      else if (excessZeroError[g])
        count_reg[g] <= count_reg[g] + 16'h0001;
    // overflow flag, a new overflow beats the clear
    always_ff @(posedge clk_sys or posedge rst)
      if (rst)
        overflow_reg[g] <= 1'b0;
      else if (excessZeroError[g] && count_reg[g] == CNT_MAX)
        overflow_reg[g] <= 1'b1;
      else if (wrHit && wrLink == 2'(g) && wrOff == OFF_IRQ_STATUS1
               && wData_reg[OVF_BIT])
        overflow_reg[g] <= 1'b0;
    // low byte frozen when the high byte is read
    always_ff @(posedge clk_sys or posedge rst)
      if (rst)
        snapLow_reg[g] <= '0;
      else if (arTake && rdLink == 2'(g) && rdOff == OFF_CNT_HI)
        snapLow_reg[g] <= count_reg[g][7:0];
    // reference outputs under loss of signal
    always_ff @(posedge clk_sys or posedge rst)
      if (rst)
      begin
        referenceOutputA[g] <= 1'b0;
        referenceOutputB[g] <= 1'b0;
      end
      else
      begin
        referenceOutputA[g] <= (signalLossStatus[g] && refHold_reg[g])
                               || mclk_reg;
        referenceOutputB[g] <= (signalLossStatus[g] && refHold_reg[g])
                               || mclk_reg;
      end
  end

  localparam int DW = $clog2(HALF_CYC);
  localparam int BW = $clog2(FRM_BITS);
  localparam int SW = $clog2(SF_LEN);
  logic [OPT_W-1:0] opt;
  logic             master;
  logic [2:0]       ckSync_reg;
  logic [1:0]       fpSync_reg;
  logic [1:0]       dSync_reg;
  logic [1:0]       sgSync_reg;
  logic [DW-1:0]    div_reg;
  logic             phase_reg;
  logic [BW-1:0]    bit_reg;
  logic [SW-1:0]    frm_reg;
  logic             pulseSeen_reg;
  logic             half_reg;
  logic             genRise;
  logic             genFall;
  logic             selRise;
  logic             selFall;
  logic             deEdge;
  logic             feEdge;
  logic             take;
  logic             fBit;
  logic             gapHide;

  assign opt = txOpt_reg[0];
  assign master = !txMode_reg[0];
  assign genRise = div_reg == DW'(HALF_CYC - 1) && !phase_reg;
  assign genFall = div_reg == DW'(HALF_CYC - 1) && phase_reg;
  assign selRise = master ? genRise : (ckSync_reg[1] && !ckSync_reg[2]);
  assign selFall = master ? genFall : (!ckSync_reg[1] && ckSync_reg[2]);
  // a gapped F-bit shows no pin edge, so no sample is taken there
  assign gapHide = master && opt[GAP_BIT]
                   && (genRise ? bit_reg == BW'(FRM_BITS - 1) : fBit);
  assign deEdge = (opt[DE_BIT] ? selRise : selFall) && !gapHide;
  assign feEdge = opt[FE_BIT] ? selRise : selFall;
  assign take = deEdge && (master || !opt[CMS_BIT] || !half_reg);
  assign fBit = bit_reg == '0;

  // pin synchronisers, first stage read only by the second
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      ckSync_reg <= '0;
      fpSync_reg <= '0;
      dSync_reg <= '0;
      sgSync_reg <= '0;
    end
    else
    begin
      ckSync_reg <= {ckSync_reg[1:0], lnk.txSystemClock};
      fpSync_reg <= {fpSync_reg[0], lnk.txSystemFramePulse};
      dSync_reg <= {dSync_reg[0], lnk.txSystemData};
      sgSync_reg <= {sgSync_reg[0], lnk.txSystemSignaling};
    end

  // own clock, bit and frame counting in master mode
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      div_reg <= '0;
      phase_reg <= 1'b0;
      bit_reg <= '0;
      frm_reg <= '0;
    end
    else if (div_reg == DW'(HALF_CYC - 1))
    begin
      div_reg <= '0;
      phase_reg <= !phase_reg;
      if (genRise)
      begin
        bit_reg <= (bit_reg == BW'(FRM_BITS - 1)) ? '0 : bit_reg + 1'b1;
        if (bit_reg == BW'(FRM_BITS - 1))
          frm_reg <= (frm_reg == SW'(SF_LEN - 1)) ? '0 : frm_reg + 1'b1;
      end
    end
    else
      div_reg <= div_reg + 1'b1;

  // clock and pulse drive toward the system side
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      lnk.devClockOut <= 1'b0;
      lnk.devClockOe <= 1'b0;
      lnk.devPulseOut <= 1'b0;
      lnk.devPulseOe <= 1'b0;
    end
    else
    begin
      lnk.devClockOe <= master;
      lnk.devPulseOe <= master;
      lnk.devClockOut <= phase_reg && !(fBit && opt[GAP_BIT]);
      if (feEdge)
        lnk.devPulseOut <= (fBit && (!opt[FRAME_PULSE_KIND_BIT] || frm_reg == '0))
                           ^ opt[FRAME_PULSE_POLARITY_BIT];
    end

  // incoming pulse on the frame edge, data on the data edge
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      pulseSeen_reg <= 1'b0;
      half_reg <= 1'b0;
      capData <= 1'b0;
      capSignaling <= 1'b0;
      capValid <= 1'b0;
      capFrameStart <= 1'b0;
    end
    else
    begin
      if (feEdge)
        pulseSeen_reg <= fpSync_reg[1] ^ opt[FRAME_PULSE_POLARITY_BIT];
      if (deEdge)
        half_reg <= !half_reg;
      capValid <= take;
      if (take)
      begin
        capData <= dSync_reg[1];
        capSignaling <= sgSync_reg[1];
        capFrameStart <= master ? fBit : pulseSeen_reg;
      end
    end
endmodule

// [core/lsb_link_if.sv]
// Purpose: transmit backplane pins between device and system side.
// Assumes: each end drives clock and pulse only while its enable is high.
// Notes: resolved wire levels are worked out here from the enables.
`timescale 1ns/1ps
interface lsb_link_if;
  logic devClockOut;
  logic devClockOe;
  logic devPulseOut;
  logic devPulseOe;
  logic sysClockOut;
  logic sysClockOe;
  logic sysPulseOut;
  logic sysPulseOe;
  logic txSystemData;
  logic txSystemSignaling;
  logic txSystemClock;
  logic txSystemFramePulse;
  // wire resolution, idle low when undriven
  assign txSystemClock = devClockOe ? devClockOut
                       : (sysClockOe ? sysClockOut : 1'b0);
  assign txSystemFramePulse = devPulseOe ? devPulseOut
                            : (sysPulseOe ? sysPulseOut : 1'b0);
  modport dev (output devClockOut, devClockOe, devPulseOut, devPulseOe,
               input txSystemClock, txSystemFramePulse,
               input txSystemData, txSystemSignaling);
  modport sys (output sysClockOut, sysClockOe, sysPulseOut, sysPulseOe,
               output txSystemData, txSystemSignaling,
               input txSystemClock, txSystemFramePulse);
endinterface

// [core/lsb_pkg.sv]
// Purpose: shared constants for the link status and transmit backplane
//   register group and its system-side partner.
// Assumes: 100 MHz clk_sys; register index = link*0x100 + offset,
//   byte address = 4 * index over AXI4-Lite.
// Notes: only link 0 settings steer the transmit backplane pins.
// Operation
// - error count read as high and low bytes
// - four link copies in 0x100 pages
// - on loss, references follow master clock or hold high
// - line summary bit set by line block interrupts
// - indication 0 maps eight framer block interrupts
// - indication 1 maps HDLC, elastic store, interface
// - master mode gaps clock during F-bit when set
// - data-edge bit picks data sampling clock edge
// - frame-edge bit picks framing pulse clock edge
// - clock-rate bit marks double-rate slave clock
// - software keeps clock rate equal on shared clock
// - software keeps mux settings equal on all links
// - polarity bit sets framing pulse active level
// - pulse type 0 marks every F-bit
// - pulse type 1 marks superframe first F-bit
// - counter overflow latches flag, write one clears
// - loss status bit follows loss detection
// - sub-mode bit: 0 master, 1 slave default
package lsb_pkg;
  localparam int ADDR_W = 12;
  localparam int LINK_LSB = 10;
  localparam int OFF_LSB = 2;
  localparam int LINKS = 4;
  localparam logic [7:0] OFF_LOS_STATUS = 8'h36;
  localparam logic [7:0] OFF_IRQ_STATUS1 = 8'h3B;
  localparam logic [7:0] OFF_CNT_HI = 8'h3C;
  localparam logic [7:0] OFF_CNT_LO = 8'h3D;
  localparam logic [7:0] OFF_REF_CTRL = 8'h3E;
  localparam logic [7:0] OFF_MOD_IND2 = 8'h3F;
  localparam logic [7:0] OFF_MOD_IND0 = 8'h40;
  localparam logic [7:0] OFF_MOD_IND1 = 8'h41;
  localparam logic [7:0] OFF_TX_OPT = 8'h42;
  localparam logic [7:0] OFF_TX_MODE = 8'h43;
  localparam int LOS_BIT = 0;
  localparam int OVF_BIT = 0;
  localparam int HOLD_BIT = 0;
  localparam int LIU_BIT = 0;
  localparam int TX_TIMING_SUBMODE_BIT = 0;
  localparam int OPT_W = 6;
  localparam int FRAME_PULSE_KIND_BIT = 0;
  localparam int FRAME_PULSE_POLARITY_BIT = 1;
  localparam int CMS_BIT = 2;
  localparam int FE_BIT = 3;
  localparam int DE_BIT = 4;
  localparam int GAP_BIT = 5;
  localparam logic [OPT_W-1:0] TX_OPT_RST = 6'h00;
  localparam logic TX_MODE_RST = 1'b1;
  localparam logic HOLD_RST = 1'b0;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int FRAME_BITS = 193;
  localparam int SF_FRAMES = 12;
  localparam int SYS_PERIOD_NS = 10;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
endpackage

// [core/lsb_system.sv]
// Purpose: system-side end of the transmit backplane.
// Assumes: settings match those programmed in link 0 of the device.
// Notes: sources clock and pulse unless the device is clock master.
`timescale 1ns/1ps
module lsb_system #(
  parameter int FRM_BITS = lsb_pkg::FRAME_BITS,
  parameter int SF_LEN = lsb_pkg::SF_FRAMES,
  parameter int HALF_CYC = lsb_pkg::LINK_HALF_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic devIsMaster,
  input  wire logic sampleClockPolarity,
  input  wire logic pulseClockPolarity,
  input  wire logic clockDoubleRate,
  input  wire logic framePulsePolarity,
  input  wire logic framePulseKind,
  input  wire logic txBitIn,
  input  wire logic txSigIn,
  output logic      bitTaken,
  output logic      frameStart,
  lsb_link_if.sys   lnk
);
  import lsb_pkg::*;

  localparam int DW = $clog2(HALF_CYC);
  localparam int BW = $clog2(FRM_BITS);
  localparam int SW = $clog2(SF_LEN);
  logic [2:0]    ckSync_reg;
  logic [1:0]    fpSync_reg;
  logic [DW-1:0] div_reg;
  logic          phase_reg;
  logic          half_reg;
  logic          pulseSeen_reg;
  logic [BW-1:0] bit_reg;
  logic [SW-1:0] frm_reg;
  logic [DW-1:0] halfTop;
  logic          rise;
  logic          fall;
  logic          launch;
  logic          feOther;
  logic          step;
  logic          fOn;

  assign halfTop = clockDoubleRate ? DW'(HALF_CYC / 2 - 1)
                                   : DW'(HALF_CYC - 1);
  assign rise = devIsMaster ? (ckSync_reg[1] && !ckSync_reg[2])
                            : (div_reg == halfTop && !phase_reg);
  assign fall = devIsMaster ? (!ckSync_reg[1] && ckSync_reg[2])
                            : (div_reg == halfTop && phase_reg);
  assign launch = sampleClockPolarity ? fall : rise;
  assign feOther = pulseClockPolarity ? fall : rise;
  assign step = launch && (devIsMaster || !clockDoubleRate || !half_reg);
  assign fOn = bit_reg == '0 && (!framePulseKind || frm_reg == '0);

  // device clock and pulse synchronisers
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      ckSync_reg <= '0;
      fpSync_reg <= '0;
    end
    else
    begin
      ckSync_reg <= {ckSync_reg[1:0], lnk.txSystemClock};
      fpSync_reg <= {fpSync_reg[0], lnk.txSystemFramePulse};
    end

  // clock divider while the system side sources the clock
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      div_reg <= '0;
      phase_reg <= 1'b0;
    end
    else if (div_reg >= halfTop)
    begin
      div_reg <= '0;
      phase_reg <= !phase_reg;
    end
    else
      div_reg <= div_reg + 1'b1;

  // bit position, realigned to the device pulse in master mode
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      bit_reg <= '0;
      frm_reg <= '0;
      half_reg <= 1'b0;
      pulseSeen_reg <= 1'b0;
    end
    else
    begin
      if (launch)
        half_reg <= !half_reg;
      if (devIsMaster && (pulseClockPolarity ? rise : fall))
        pulseSeen_reg <= fpSync_reg[1] ^ framePulsePolarity;
      if (step)
      begin
        if (devIsMaster && pulseSeen_reg)
          bit_reg <= BW'(1);
        else
          bit_reg <= (bit_reg == BW'(FRM_BITS - 1)) ? '0 : bit_reg + 1'b1;
        if (bit_reg == BW'(FRM_BITS - 1))
          frm_reg <= (frm_reg == SW'(SF_LEN - 1)) ? '0 : frm_reg + 1'b1;
      end
    end

  // drive clock, pulse and data toward the device
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      lnk.sysClockOut <= 1'b0;
      lnk.sysClockOe <= 1'b0;
      lnk.sysPulseOut <= 1'b0;
      lnk.sysPulseOe <= 1'b0;
      lnk.txSystemData <= 1'b0;
      lnk.txSystemSignaling <= 1'b0;
      bitTaken <= 1'b0;
      frameStart <= 1'b0;
    end
    else
    begin
      lnk.sysClockOe <= !devIsMaster;
      lnk.sysPulseOe <= !devIsMaster;
      lnk.sysClockOut <= phase_reg;
      if (feOther)
        lnk.sysPulseOut <= fOn ^ framePulsePolarity;
      bitTaken <= step;
      if (step)
      begin
        lnk.txSystemData <= txBitIn;
        lnk.txSystemSignaling <= txSigIn;
        frameStart <= bit_reg == '0;
      end
    end
endmodule
